// ### sbr_pkg.sv
/*
 * Constants, types and register map of the serial receiver with baud
 * generators and mute / wake-up logic.
 * Assumes a 32-bit classic Wishbone slave port with byte addressing.
 */
package sbr_pkg;

	// ****************************************
	// Register byte addresses
	// ****************************************
	localparam logic [7:0] ADR_STATUS = 8'h00;
	localparam logic [7:0] ADR_DATA   = 8'h04;
	localparam logic [7:0] ADR_CTRL1  = 8'h08;
	localparam logic [7:0] ADR_CTRL2  = 8'h0C;
	localparam logic [7:0] ADR_BAUD   = 8'h10;
	localparam logic [7:0] ADR_EXT_RX = 8'h14;
	localparam logic [7:0] ADR_EXT_TX = 8'h18;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int ST_FULL  = 5;
	localparam int ST_IDLE  = 4;
	localparam int ST_OVR   = 3;
	localparam int ST_NOISE = 2;
	localparam int ST_FERR  = 1;
	localparam int C1_NINTH = 7;
	localparam int C1_WLEN9 = 4;
	localparam int C1_WAKE  = 3;
	localparam int C2_RXIE  = 5;
	localparam int C2_IDIE  = 4;
	localparam int C2_RXEN  = 2;
	localparam int C2_MUTE  = 1;
	localparam int BR_PSEL  = 6;
	localparam int BR_TSEL  = 3;
	localparam int BR_RSEL  = 0;

	// ****************************************
	// Divider and sampling counts
	// ****************************************
	localparam logic [4:0] PRESCALE_0 = 5'h01;
	localparam logic [4:0] PRESCALE_1 = 5'h03;
	localparam logic [4:0] PRESCALE_2 = 5'h04;
	localparam logic [4:0] PRESCALE_3 = 5'h0D;
	localparam logic [4:0] SMP_LAST   = 5'h10;
	localparam logic [4:0] SMP_A      = 5'h08;
	localparam logic [4:0] SMP_B      = 5'h09;
	localparam logic [4:0] SMP_C      = 5'h0A;
	localparam logic [3:0] BITS_8     = 4'h8;
	localparam logic [3:0] BITS_9     = 4'h9;
	localparam logic [7:0] FRAME8_TICKS = 8'hA0;
	localparam logic [7:0] FRAME9_TICKS = 8'hB0;

	typedef enum logic [1:0] {
		RX_HUNT  = 2'b00,
		RX_START = 2'b01,
		RX_DATA  = 2'b10,
		RX_STOP  = 2'b11
	} sbr_rx_e;

	typedef struct packed {
		logic        ack;
		logic [7:0]  rdat;
		logic        arm;
		logic        full;
		logic        idle;
		logic        ovr;
		logic        noise;
		logic        ferr;
		logic [7:0]  rbuf;
		logic        ninth;
		logic        wlen9;
		logic        wake;
		logic        rxie;
		logic        idie;
		logic        rx_en;
		logic        mute;
		logic [1:0]  psel;
		logic [2:0]  tsel;
		logic [2:0]  rsel;
		logic [7:0]  ext_rx;
		logic [7:0]  ext_tx;
		logic [18:0] rxdiv;
		logic [18:0] txdiv;
		logic        txtick;
		sbr_rx_e     st;
		logic [4:0]  scnt;
		logic [3:0]  bcnt;
		logic [8:0]  sh;
		logic [2:0]  samp;
		logic        edge_ok;
		logic        fnoise;
		logic        hnoise;
		logic [2:0]  hist;
		logic [7:0]  icnt;
		logic        iarm;
		logic        irq;
	} sbr_state_s;

	localparam sbr_state_s STATE_RST = '0;

endpackage : sbr_pkg

// ### sbr_rx.sv
/*
 * Serial receiver with transmit / receive baud generators, flags,
 * overrun, noise, framing, idle detection and mute / wake-up.
 * Assumes rxd_i and irq_mask_i are synchronous to clk_i.
 */
// Behaviour
// - Enabling the receiver starts start-bit hunting with the chosen word length.
// - Completed word goes to holding buffer, sets full flag, may interrupt.
// - Full flag clears only by status read then data read.
// - Break character is handled exactly as a framing error.
// - Idle frame sets idle flag only, not full flag or buffer, plus idle interrupt if enabled.
// - Word completing while full sets overrun, keeps buffer, may interrupt.
// - Overrun clears by status read then data read.
// - Bit clean only if samples 8, 9, 10 agree; start adds edge check.
// - Noise flag rises with full flag; data still transferred; no own interrupt.
// - Noise flag clears by status read then data read.
// - False start discards frame; hidden noise shows with next valid frame.
// - Missing stop bit or break sets framing error with full flag.
// - Framing error clears by status read then data read.
// - Each direction divides clock by 16, shared prescale and own factor.
// - Prescale is 1, 3, 4 or 13; rate factors are 1 to 128.
// - Nonzero extended prescaler divides that direction further; zero does nothing.
// - While muted no receive status bits set and no receive interrupts.
// - Idle wake method: idle frame clears mute without setting idle flag.
// - Address wake method: word with top bit one unmutes and is received.
// - In 9-bit mode the received ninth bit goes to control register one.
// - Frame is start bit, 8 or 9 data bits LSB first, stop bit.
// - Each bit sampled 16 times, stop bit only up to sample 10; value is majority of samples 8-10.
module sbr_rx (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        rxd_i,
	input  wire logic        irq_mask_i,
	output logic             rx_irq_o,
	output logic             tx_baud_tick_o
);

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic maj3(input logic [2:0] s);
		maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
	endfunction : maj3

	function automatic logic [18:0] baud_div(input logic [1:0] psel, input logic [2:0] sel,
			input logic [7:0] ext);
		logic [4:0]  pr;
		logic [10:0] base;
		case (psel)
			2'h0:    pr = sbr_pkg::PRESCALE_0;
			2'h1:    pr = sbr_pkg::PRESCALE_1;
			2'h2:    pr = sbr_pkg::PRESCALE_2;
			default: pr = sbr_pkg::PRESCALE_3;
		endcase
		base = 11'(pr) << sel;
		if (ext == 8'h00) begin
			baud_div = 19'(base);
		end else begin
			baud_div = 19'(base) * 19'(ext);
		end
	endfunction : baud_div

	sbr_pkg::sbr_state_s q;
	sbr_pkg::sbr_state_s d;

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic       acc;
		logic       clr;
		logic       tick;
		logic [4:0] sn;
		logic       done;
		logic       idle_ev;
		logic       stopb;
		logic       snz;
		logic [8:0] word;
		logic       msb;
		logic [7:0] ilen;
		acc     = wb_cyc_i & wb_stb_i & ~q.ack;
		clr     = acc & ~wb_we_i & (wb_adr_i == sbr_pkg::ADR_DATA) & q.arm;
		tick    = 1'b0;
		sn      = (q.scnt == sbr_pkg::SMP_LAST) ? 5'h01 : q.scnt + 5'h01;
		done    = 1'b0;
		idle_ev = 1'b0;
		stopb   = maj3({rxd_i, q.samp[1:0]});
		snz     = (q.samp[1:0] != {2{rxd_i}}) | (q.samp[0] != q.samp[1]);
		word    = q.wlen9 ? q.sh : {1'b0, q.sh[8:1]};
		msb     = q.wlen9 ? word[8] : word[7];
		ilen    = q.wlen9 ? sbr_pkg::FRAME9_TICKS - 8'h01 : sbr_pkg::FRAME8_TICKS - 8'h01;
		d        = q;
		d.ack    = 1'b0;
		d.txtick = 1'b0;

		// Bus read path, answer one cycle after the request
		if (acc) begin
			d.ack = 1'b1;
			case (wb_adr_i)
				sbr_pkg::ADR_STATUS: d.rdat = {2'b00, q.full, q.idle, q.ovr, q.noise, q.ferr, 1'b0};
				sbr_pkg::ADR_DATA:   d.rdat = q.rbuf;
				sbr_pkg::ADR_CTRL1:  d.rdat = {q.ninth, 2'b00, q.wlen9, q.wake, 3'b000};
				sbr_pkg::ADR_CTRL2:  d.rdat = {2'b00, q.rxie, q.idie, 1'b0, q.rx_en, q.mute, 1'b0};
				sbr_pkg::ADR_BAUD:   d.rdat = {q.psel, q.tsel, q.rsel};
				sbr_pkg::ADR_EXT_RX: d.rdat = q.ext_rx;
				sbr_pkg::ADR_EXT_TX: d.rdat = q.ext_tx;
				default:             d.rdat = 8'h00;
			endcase
			if (!wb_we_i && wb_adr_i == sbr_pkg::ADR_STATUS) begin
				d.arm = 1'b1;
			end else if (!wb_we_i && wb_adr_i == sbr_pkg::ADR_DATA) begin
				d.arm = 1'b0;
			end
		end

		if (clr) begin
			d.full  = 1'b0;
			d.ovr   = 1'b0;
			d.noise = 1'b0;
			d.ferr  = 1'b0;
			d.idle  = 1'b0;
		end

		if (q.txdiv == 19'h0) begin
			d.txdiv  = baud_div(q.psel, q.tsel, q.ext_tx) - 19'h1;
			d.txtick = 1'b1;
		end else begin
			d.txdiv = q.txdiv - 19'h1;
		end

		if (!q.rx_en) begin
			d.rxdiv = 19'h0;
			d.st    = sbr_pkg::RX_HUNT;
			d.scnt  = 5'h00;
			d.hist  = 3'h0;
			d.icnt  = 8'h00;
			d.iarm  = 1'b1;
		end else begin
			if (q.rxdiv == 19'h0) begin
				d.rxdiv = baud_div(q.psel, q.rsel, q.ext_rx) - 19'h1;
				tick    = 1'b1;
			end else begin
				d.rxdiv = q.rxdiv - 19'h1;
			end
		end

		if (tick) begin
			if (q.st != sbr_pkg::RX_HUNT) begin
				d.scnt = sn;
				// Keep samples 8, 9 and 10
				case (sn)
					sbr_pkg::SMP_A: d.samp[0] = rxd_i;
					sbr_pkg::SMP_B: d.samp[1] = rxd_i;
					sbr_pkg::SMP_C: d.samp[2] = rxd_i;
					default:        d.samp = q.samp;
				endcase
			end
			case (q.st)
				sbr_pkg::RX_HUNT: begin
					d.hist = {q.hist[1:0], rxd_i};
					if (!rxd_i) begin
						d.st      = sbr_pkg::RX_START;
						d.scnt    = 5'h01;
						d.edge_ok = (q.hist == 3'h7);
						d.fnoise  = 1'b0;
						d.icnt    = 8'h00;
					end else if (q.icnt != ilen) begin
						d.icnt = q.icnt + 8'h01;
					end else if (q.iarm) begin
						idle_ev = 1'b1;
						d.iarm  = 1'b0;
					end
				end
				sbr_pkg::RX_START: begin
					if ((sn == 5'h03 || sn == 5'h05 || sn == 5'h07) && rxd_i) begin
						d.fnoise = 1'b1;
					end
					if (sn == sbr_pkg::SMP_LAST) begin
						if (maj3(q.samp)) begin
							d.hnoise = 1'b1;
							d.st     = sbr_pkg::RX_HUNT;
							d.hist   = 3'h0;
						end else begin
							if (q.samp != 3'h0 || !q.edge_ok) begin
								d.fnoise = 1'b1;
							end
							d.st   = sbr_pkg::RX_DATA;
							d.bcnt = 4'h0;
						end
					end
				end
				sbr_pkg::RX_DATA: begin
					if (sn == sbr_pkg::SMP_LAST) begin
						d.sh   = {maj3(q.samp), q.sh[8:1]};
						if (q.samp != 3'h0 && q.samp != 3'h7) begin
							d.fnoise = 1'b1;
						end
						d.bcnt = q.bcnt + 4'h1;
						if (q.bcnt == (q.wlen9 ? sbr_pkg::BITS_9 : sbr_pkg::BITS_8) - 4'h1) begin
							d.st = sbr_pkg::RX_STOP;
						end
					end
				end
				sbr_pkg::RX_STOP: begin
					// Ends at mid stop so the next start edge is not missed
					if (sn == sbr_pkg::SMP_C) begin
						done   = 1'b1;
						d.st   = sbr_pkg::RX_HUNT;
						d.hist = 3'h0;
						d.icnt = 8'h00;
					end
				end
				default: d.st = sbr_pkg::RX_HUNT;
			endcase
		end

		// Frame completion
		if (done) begin
			d.iarm = 1'b1;
			if (!q.mute || (q.wake && msb)) begin
				d.mute = 1'b0;
				if (d.full) begin
					d.ovr = 1'b1;
				end else begin
					d.rbuf  = word[7:0];
					d.ninth = word[8];
					d.full  = 1'b1;
					d.noise = q.fnoise | snz | q.hnoise;
					d.ferr  = ~stopb;
					d.hnoise = 1'b0;
				end
			end
		end

		if (idle_ev) begin
			if (q.mute) begin
				if (!q.wake) begin
					d.mute = 1'b0;
				end
			end else begin
				d.idle = 1'b1;
			end
		end

		// Writes; a mute write wins over hardware wake
		if (acc && wb_we_i && wb_sel_i[0]) begin
			case (wb_adr_i)
				sbr_pkg::ADR_CTRL1: begin
					d.wlen9 = wb_dat_i[sbr_pkg::C1_WLEN9];
					d.wake  = wb_dat_i[sbr_pkg::C1_WAKE];
				end
				sbr_pkg::ADR_CTRL2: begin
					d.rxie  = wb_dat_i[sbr_pkg::C2_RXIE];
					d.idie  = wb_dat_i[sbr_pkg::C2_IDIE];
					d.rx_en = wb_dat_i[sbr_pkg::C2_RXEN];
					d.mute  = wb_dat_i[sbr_pkg::C2_MUTE];
				end
				sbr_pkg::ADR_BAUD: begin
					d.psel = wb_dat_i[sbr_pkg::BR_PSEL +: 2];
					d.tsel = wb_dat_i[sbr_pkg::BR_TSEL +: 3];
					d.rsel = wb_dat_i[sbr_pkg::BR_RSEL +: 3];
				end
				sbr_pkg::ADR_EXT_RX: d.ext_rx = wb_dat_i[7:0];
				sbr_pkg::ADR_EXT_TX: d.ext_tx = wb_dat_i[7:0];
				default:             d.ext_tx = d.ext_tx;
			endcase
		end

		d.irq = ~irq_mask_i & ~d.mute &
			((d.rxie & (d.full | d.ovr)) | (d.idie & d.idle));
	end

	// ****************************************
	// State register
	// ****************************************
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= sbr_pkg::STATE_RST;
		end else begin
			q <= d;
		end
	end

	assign wb_dat_o       = {24'h000000, q.rdat};
	assign wb_ack_o       = q.ack;
	assign rx_irq_o       = q.irq;
	assign tx_baud_tick_o = q.txtick;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");

	rx_off_hunt_a: assert property (!q.rx_en |=> q.st == sbr_pkg::RX_HUNT)
		else $error("receiver active while disabled");

	full_irq_a: assert property ($rose(q.full) && q.rxie && !q.mute && !$past(irq_mask_i)
		|-> rx_irq_o)
		else $error("full flag without interrupt");

	full_clear_a: assert property ($fell(q.full) |->
		$past(q.arm && wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i == sbr_pkg::ADR_DATA))
		else $error("full flag cleared without sequence");

	ovr_keep_a: assert property ($rose(q.ovr) |-> $stable(q.rbuf) && q.full)
		else $error("buffer changed on overrun");

	ovr_clear_a: assert property ($fell(q.ovr) |-> $past(q.arm) && !q.arm)
		else $error("overrun cleared without sequence");

	noise_full_a: assert property ($rose(q.noise) |-> $rose(q.full))
		else $error("noise rose without full flag");

	ferr_full_a: assert property ($rose(q.ferr) |-> $rose(q.full))
		else $error("framing error rose without full flag");

	mute_quiet_a: assert property ($past(q.mute) && q.mute |-> !$rose(q.full) && !$rose(q.idle))
		else $error("status set while muted");

	irq_mask_a: assert property (irq_mask_i |=> !rx_irq_o)
		else $error("interrupt while globally masked");

endmodule : sbr_rx

// ### sbr_serial_src.sv
/*
 * Model of the remote transmitter driving the receive line.
 * Assumes the bench holds word, length, stop level, glitch and bit scale during a frame.
 * Bit length is BIT_CLKS times the scale, to match the receiver's divider.
 */
module sbr_serial_src #(
	parameter int BIT_CLKS = 16
) (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic [8:0] word_i,
	input  wire logic [3:0] nbits_i,
	input  wire logic       stop_i,
	input  wire logic       glitch_i,
	input  wire logic [7:0] scale_i,
	output logic            rxd_o
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Bit driver
	// ****************************************
	// Glitch hits one clock only, so the majority still holds
	task automatic send_bit(input logic b, input logic g);
		for (int c = 0; c < BIT_CLKS * int'(scale_i); c++) begin
			rxd_o <= (g && c == 8) ? ~b : b;
			@(posedge clk_i);
		end
	endtask : send_bit

	// ****************************************
	// Frame sequencer
	// ****************************************
	initial begin
		rxd_o = 1'b1;
		forever begin
			@(posedge clk_i);
			if (go_i) begin
				send_bit(1'b0, 1'b0);
				for (int i = 0; i < 9; i++) begin
					if (i < int'(nbits_i)) begin
						send_bit(word_i[i], glitch_i && i == 0);
					end
				end
				send_bit(stop_i, 1'b0);
				rxd_o <= 1'b1;
			end
		end
	end

endmodule : sbr_serial_src

// ### tb_top.sv
/*
 * Self-checking bench for the serial receiver.
 * Assumes a one-cycle registered ack and a 16 clock bit at reset baud.
 */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Signals
	// ****************************************
	localparam logic [31:0] FLAGS = 32'h0000002E;
	localparam logic [31:0] ALL   = 32'hFFFFFFFF;
	logic        clk, rst, cyc, stb, we, go, stop, glitch, mask, ack, irq, tick, rxd;
	logic [7:0]  adr;
	logic [31:0] wdat, dat_o, rdat;
	logic [8:0]  word;
	logic [3:0]  nbits;
	logic [7:0]  scale;
	int          err_total, compares;

	sbr_rx sbr_rx_inst (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .rxd_i(rxd), .irq_mask_i(mask), .rx_irq_o(irq),
		.tx_baud_tick_o(tick));
	sbr_serial_src sbr_serial_src_inst (.clk_i(clk), .go_i(go), .word_i(word),
		.nbits_i(nbits), .stop_i(stop), .glitch_i(glitch), .scale_i(scale), .rxd_o(rxd));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic summarize();
		if (err_total == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : summarize

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			err_total++;
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 20) begin
			err_total++;
			summarize();
		end
		@(posedge clk);
	endtask : bus

	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic send(input logic [8:0] w, input int n, input logic s, input logic g);
		word <= w;
		nbits <= 4'(n);
		stop <= s;
		glitch <= g;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (((n + 2) * 16 + 4) * int'(scale)) @(posedge clk);
	endtask : send

	task automatic gap(input int exp);
		int n;
		n = 0;
		while (tick !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		@(posedge clk);
		n = 1;
		while (tick !== 1'b1 && n < 9000) begin
			@(posedge clk);
			n++;
		end
		chk(32'(n), 32'(exp));
		if (n >= 9000) begin
			summarize();
		end
	endtask : gap

	task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		rd(a);
		chk(rdat & m, exp);
	endtask : rdc

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rdc(sbr_pkg::ADR_CTRL2, ALL, 32'h0);
		rdc(sbr_pkg::ADR_BAUD, ALL, 32'h0);
		wr(8'h1C, 32'hFF);
		rdc(8'h1C, ALL, 32'h0);
	endtask : t_regs

	task automatic t_baud();
		wr(sbr_pkg::ADR_BAUD, 32'hC8);
		gap(26);
		wr(sbr_pkg::ADR_EXT_TX, 32'h03);
		gap(78);
		wr(sbr_pkg::ADR_BAUD, 32'h00);
	endtask : t_baud

	task automatic t_basic();
		wr(sbr_pkg::ADR_CTRL2, 32'h24);
		send(9'h0A5, 8, 1'b1, 1'b0);
		chk({31'h0, irq}, 32'h1);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'hA5);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h20);
		rd(sbr_pkg::ADR_DATA);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h0);
	endtask : t_basic

	task automatic t_idle();
		wr(sbr_pkg::ADR_CTRL2, 32'h14);
		repeat (180) @(posedge clk);
		rdc(sbr_pkg::ADR_STATUS, 32'h10, 32'h10);
		chk({31'h0, irq}, 32'h1);
		rd(sbr_pkg::ADR_DATA);
	endtask : t_idle

	task automatic t_overrun();
		wr(sbr_pkg::ADR_CTRL2, 32'h24);
		mask <= 1'b1;
		send(9'h03C, 8, 1'b1, 1'b0);
		send(9'h0C3, 8, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h28);
		chk({31'h0, irq}, 32'h0);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'h3C);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h0);
		mask <= 1'b0;
	endtask : t_overrun

	task automatic t_frame();
		send(9'h055, 8, 1'b0, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h22);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'h55);
		// Low stop tail reads as a false start, so hidden noise shows here
		send(9'h000, 8, 1'b0, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h26);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'h0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h0);
	endtask : t_frame

	task automatic t_noise();
		// Break tail left hidden noise; a clean frame uncovers it
		send(9'h0A5, 8, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h24);
		rd(sbr_pkg::ADR_DATA);
		send(9'h05A, 8, 1'b1, 1'b1);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h24);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'h5A);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h0);
	endtask : t_noise

	// No control two write while muted
	task automatic t_mute();
		wr(sbr_pkg::ADR_CTRL1, 32'h08);
		wr(sbr_pkg::ADR_CTRL2, 32'h26);
		send(9'h005, 8, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h0);
		chk({31'h0, irq}, 32'h0);
		send(9'h085, 8, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h20);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'h85);
		rdc(sbr_pkg::ADR_CTRL2, ALL, 32'h24);
	endtask : t_mute

	task automatic t_ninth();
		wr(sbr_pkg::ADR_CTRL1, 32'h10);
		send(9'h1A5, 9, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_CTRL1, 32'h80, 32'h80);
		rd(sbr_pkg::ADR_STATUS);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'hA5);
	endtask : t_ninth

	task automatic t_idle_wake();
		wr(sbr_pkg::ADR_CTRL1, 32'h00);
		wr(sbr_pkg::ADR_CTRL2, 32'h06);
		repeat (200) @(posedge clk);
		rdc(sbr_pkg::ADR_CTRL2, ALL, 32'h04);
		rdc(sbr_pkg::ADR_STATUS, 32'h10, 32'h0);
	endtask : t_idle_wake

	// Receiver off while its divider changes
	task automatic t_rx_rate();
		wr(sbr_pkg::ADR_CTRL2, 32'h00);
		wr(sbr_pkg::ADR_BAUD, 32'h01);
		wr(sbr_pkg::ADR_EXT_RX, 32'h03);
		wr(sbr_pkg::ADR_CTRL2, 32'h04);
		// Bit is 2 x 3 x 16 clocks; wait for three high ticks
		scale <= 8'h06;
		repeat (40) @(posedge clk);
		send(9'h0C3, 8, 1'b1, 1'b0);
		rdc(sbr_pkg::ADR_STATUS, FLAGS, 32'h20);
		rdc(sbr_pkg::ADR_DATA, ALL, 32'hC3);
	endtask : t_rx_rate

	// ****************************************
	// Clock and main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		{rst, cyc, stb, we, go, stop, glitch, mask} = 8'h80;
		adr = 8'h00;
		wdat = 32'h0;
		word = 9'h0;
		nbits = 4'h8;
		scale = 8'h01;
		err_total = 0;
		compares = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs();
		t_baud();
		t_basic();
		t_idle();
		t_overrun();
		t_frame();
		t_noise();
		t_mute();
		t_ninth();
		t_idle_wake();
		t_rx_rate();
		summarize();
	end

endmodule : tb_top
